/* dcr_top.v */
/*
 * dcr_top.v: decode of 24-bit serial words into the control register
 * group, storage of main and per-channel control fields, watchdog timer.
 * Assumes a framed word arrives with a one-cycle strobe on i_clk_sys
 * from the serial front end; the polarity pin is asynchronous.
 */
`default_nettype none

`include "dcr_map.vh"

module dcr_top
#(
    parameter [31:0] WD_CYC0 = `DCR_CLK_HZ / 1000 * `DCR_WD_MS0,
    parameter [31:0] WD_CYC1 = `DCR_CLK_HZ / 1000 * `DCR_WD_MS1,
    parameter [31:0] WD_CYC2 = `DCR_CLK_HZ / 1000 * `DCR_WD_MS2,
    parameter [31:0] WD_CYC3 = `DCR_CLK_HZ / 1000 * `DCR_WD_MS3
)
(
    // clock and reset
    input  wire                   i_clk_sys,
    input  wire                   i_rst_n,
    // serial word in
    input  wire                   i_word_vld,
    input  wire [`DCR_WORD_W-1:0] i_word,
    // polarity pin
    input  wire                   i_polarity_pin,
    // main control fields
    output reg                    o_status_readback_enable,
    output reg                    o_watchdog_enable,
    output reg  [1:0]             o_watchdog_timeout_select,
    output reg                    o_short_limit_select,
    output reg                    o_global_output_enable,
    output reg                    o_global_regulator_power,
    output reg                    o_watchdog_fault,
    // per-channel fields
    output reg  [3:0]             o_channel_power_up,
    output reg  [3:0]             o_channel_zeroing_select,
    output reg  [3:0]             o_channel_output_enable,
    output reg  [3:0]             o_sense_resistor_select,
    output reg  [3:0]             o_channel_regulator_power,
    output reg  [3:0]             o_voltage_overrange_enable,
    output reg  [11:0]            o_output_range_select,
    output reg  [3:0]             o_voltage_pin_level,
    // strobes for registers held elsewhere
    output reg                    o_slew_wr,
    output reg                    o_regulator_ctrl_wr,
    output reg                    o_software_wr,
    output reg  [15:0]            o_ctrl_data
);

    // ****************************************
    // decode
    // ****************************************
    wire       ctrl_hit;
    wire [2:0] sub_addr;
    wire [1:0] ch_addr;
    wire       wr_main;
    wire       wr_chan;
    wire       pol_pin_s;

    assign ctrl_hit = i_word_vld &
                      (i_word[`DCR_SEL_HI:`DCR_SEL_LO] == `DCR_SEL_CTRL);
    assign sub_addr = i_word[`DCR_SUB_HI:`DCR_SUB_LO];
    assign ch_addr  = i_word[`DCR_CH_HI:`DCR_CH_LO];
    assign wr_main  = ctrl_hit & (sub_addr == `DCR_SUB_MAIN);
    assign wr_chan  = ctrl_hit & (sub_addr == `DCR_SUB_CHAN);

    dcr_sync u_pol_sync
    (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (i_polarity_pin),
        .o_sync    (pol_pin_s)
    );

    // ****************************************
    // main control register
    // ****************************************
    reg [15:0] main_control_q;

    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            main_control_q <= `DCR_MAIN_RST;
        end
        else if (wr_main)
        begin
            main_control_q <= i_word[15:0];
        end
    end

    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_status_readback_enable  <= 1'b0;
            o_watchdog_enable         <= 1'b0;
            o_watchdog_timeout_select <= 2'h0;
            o_short_limit_select      <= 1'b0;
            o_global_output_enable    <= 1'b0;
            o_global_regulator_power  <= 1'b0;
        end
        else
        begin
            o_status_readback_enable  <= main_control_q[`DCR_M_STAT];
            o_watchdog_enable         <= main_control_q[`DCR_M_WDEN];
            o_watchdog_timeout_select <= main_control_q[`DCR_M_WD_HI:`DCR_M_WD_LO];
            o_short_limit_select      <= main_control_q[`DCR_M_SHORT];
            o_global_output_enable    <= main_control_q[`DCR_M_OEALL];
            o_global_regulator_power  <= main_control_q[`DCR_M_REGALL];
        end
    end

    // ****************************************
    // strobes to other control registers
    // ****************************************
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_slew_wr           <= 1'b0;
            o_regulator_ctrl_wr <= 1'b0;
            o_software_wr       <= 1'b0;
            o_ctrl_data         <= 16'h0000;
        end
        else
        begin
            o_slew_wr           <= ctrl_hit & (sub_addr == `DCR_SUB_SLEW);
            o_regulator_ctrl_wr <= ctrl_hit & (sub_addr == `DCR_SUB_REG);
            o_software_wr       <= ctrl_hit & (sub_addr == `DCR_SUB_SOFT);
            if (ctrl_hit)
            begin
                o_ctrl_data <= i_word[15:0];
            end
        end
    end

    // ****************************************
    // watchdog
    // ****************************************
    reg  [31:0] wd_cnt_q;
    reg  [31:0] wd_limit;
    wire        wd_kick;

    assign wd_kick = ctrl_hit & (sub_addr == `DCR_SUB_SOFT) &
                     (i_word[11:0] == `DCR_WD_KICK);

    always @*
    begin
        case (main_control_q[`DCR_M_WD_HI:`DCR_M_WD_LO])
            2'h0:    wd_limit = WD_CYC0;
            2'h1:    wd_limit = WD_CYC1;
            2'h2:    wd_limit = WD_CYC2;
            default: wd_limit = WD_CYC3;
        endcase
    end

    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wd_cnt_q         <= 32'h00000000;
            o_watchdog_fault <= 1'b0;
        end
        else if (!main_control_q[`DCR_M_WDEN])
        begin
            wd_cnt_q         <= 32'h00000000;
            o_watchdog_fault <= 1'b0;
        end
        else if (wd_kick)
        begin
            // a timeout in the kick cycle still raises the fault
            wd_cnt_q         <= 32'h00000000;
            o_watchdog_fault <= ~o_watchdog_fault & (wd_cnt_q == wd_limit - 32'h00000001);
        end
        else if (wd_cnt_q >= wd_limit - 32'h00000001)
        begin
            o_watchdog_fault <= 1'b1;
        end
        else
        begin
            wd_cnt_q <= wd_cnt_q + 32'h00000001;
        end
    end

    // ****************************************
    // per-channel converter control
    // ****************************************
    wire [`DCR_CHAN_W-1:0] ch_ctrl [0:3];
    wire [3:0]             ch_oe;
    wire [3:0]             ch_reg;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_chan
            dcr_chan u_chan
            (
                .i_clk_sys (i_clk_sys),
                .i_rst_n   (i_rst_n),
                .i_wr      (wr_chan & ({30'h0, ch_addr} == g)),
                .i_data    (i_word[`DCR_CHAN_W-1:0]),
                .i_oe_all  (main_control_q[`DCR_M_OEALL]),
                .i_reg_all (main_control_q[`DCR_M_REGALL]),
                .o_ctrl    (ch_ctrl[g]),
                .o_out_en  (ch_oe[g]),
                .o_reg_on  (ch_reg[g])
            );

            always @(posedge i_clk_sys or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    o_channel_power_up[g]         <= 1'b0;
                    o_channel_zeroing_select[g]   <= 1'b0;
                    o_channel_output_enable[g]    <= 1'b0;
                    o_sense_resistor_select[g]    <= 1'b0;
                    o_channel_regulator_power[g]  <= 1'b0;
                    o_voltage_overrange_enable[g] <= 1'b0;
                    o_output_range_select[3*g+2:3*g] <= 3'h0;
                    o_voltage_pin_level[g]        <= 1'b0;
                end
                else
                begin
                    o_channel_power_up[g]         <= ch_ctrl[g][`DCR_C_PWR];
                    o_channel_zeroing_select[g]   <= ch_ctrl[g][`DCR_C_CLR];
                    o_channel_output_enable[g]    <= ch_oe[g];
                    o_sense_resistor_select[g]    <= ch_ctrl[g][`DCR_C_RSNS];
                    o_channel_regulator_power[g]  <= ch_reg[g];
                    o_voltage_overrange_enable[g] <= ch_ctrl[g][`DCR_C_OVR];
                    o_output_range_select[3*g+2:3*g] <=
                        ch_ctrl[g][`DCR_C_RNG_HI:`DCR_C_RNG_LO];
                    o_voltage_pin_level[g] <=
                        pol_pin_s ^ main_control_q[`DCR_M_POL];
                end
            end
        end
    endgenerate

endmodule // dcr_top

`default_nettype wire

/* dcr_map.vh */
/*
 * dcr_map.vh: word layout, sub-addresses, field positions, reset values
 * and timing counts for the control register decode block.
 * Assumes a 100 MHz system clock; included by bare name.
 */
`ifndef DCR_MAP_VH
`define DCR_MAP_VH

// ****************************************
// serial word layout
// ****************************************
`define DCR_WORD_W        24
`define DCR_SEL_HI        20
`define DCR_SEL_LO        18
`define DCR_SEL_CTRL      3'h7
`define DCR_CH_HI         17
`define DCR_CH_LO         16
`define DCR_SUB_HI        15
`define DCR_SUB_LO        13

// ****************************************
// control sub-addresses
// ****************************************
`define DCR_SUB_SLEW      3'h0
`define DCR_SUB_MAIN      3'h1
`define DCR_SUB_CHAN      3'h2
`define DCR_SUB_REG       3'h3
`define DCR_SUB_SOFT      3'h4

// ****************************************
// main control fields
// ****************************************
`define DCR_M_POL         12
`define DCR_M_STAT        11
`define DCR_M_WDEN        10
`define DCR_M_WD_HI       9
`define DCR_M_WD_LO       8
`define DCR_M_SHORT       6
`define DCR_M_OEALL       5
`define DCR_M_REGALL      4
`define DCR_MAIN_RST      16'h0000

// ****************************************
// channel control fields
// ****************************************
`define DCR_C_PWR         8
`define DCR_C_CLR         7
`define DCR_C_OE          6
`define DCR_C_RSNS        5
`define DCR_C_REG         4
`define DCR_C_OVR         3
`define DCR_C_RNG_HI      2
`define DCR_C_RNG_LO      0
`define DCR_CHAN_RST      9'h000
`define DCR_CHAN_W        9

// ****************************************
// watchdog timeouts (ms) and clock rate
// ****************************************
`define DCR_CLK_HZ        100000000
`define DCR_WD_MS0        5
`define DCR_WD_MS1        10
`define DCR_WD_MS2        100
`define DCR_WD_MS3        200
`define DCR_WD_KICK       12'h195

`endif

/* dcr_sync.v */
/*
 * dcr_sync.v: two flip-flop synchroniser for one level.
 * Assumes the input is asynchronous to i_clk_sys.
 */
`default_nettype none

module dcr_sync
(
    // clock and reset
    input  wire i_clk_sys,
    input  wire i_rst_n,
    // level
    input  wire i_async,
    output wire o_sync
);

    reg meta_q;
    reg sync_q;

    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule // dcr_sync

`default_nettype wire

/* dcr_chan.v */
/*
 * dcr_chan.v: one channel's converter control copy and its output drive.
 * Assumes the write strobe is already decoded for this channel.
 */
`default_nettype none

`include "dcr_map.vh"

module dcr_chan
(
    // clock and reset
    input  wire                      i_clk_sys,
    input  wire                      i_rst_n,
    // write
    input  wire                      i_wr,
    input  wire [`DCR_CHAN_W-1:0]    i_data,
    // globals
    input  wire                      i_oe_all,
    input  wire                      i_reg_all,
    // fields
    output wire [`DCR_CHAN_W-1:0]    o_ctrl,
    output reg                       o_out_en,
    output reg                       o_reg_on
);

    reg [`DCR_CHAN_W-1:0] ctrl_q;

    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_q   <= `DCR_CHAN_RST;
            o_out_en <= 1'b0;
            o_reg_on <= 1'b0;
        end
        else
        begin
            if (i_wr)
            begin
                ctrl_q <= i_data;
            end
            o_out_en <= ctrl_q[`DCR_C_OE] | i_oe_all;
            o_reg_on <= ctrl_q[`DCR_C_REG] | i_reg_all;
        end
    end

    assign o_ctrl = ctrl_q;

endmodule // dcr_chan

`default_nettype wire

/* dcr_monitor.sv */
/* dcr_monitor.sv: port assertions for the control register decode block.
   Assumes it is bound into every dcr_top instance. */
`default_nettype none
module dcr_monitor
(
    // clock and reset
    input wire logic        i_clk_sys,
    input wire logic        i_rst_n,
    // word in
    input wire logic        i_word_vld,
    input wire logic [23:0] i_word,
    // fields
    input wire logic        o_status_readback_enable,
    input wire logic        o_watchdog_enable,
    input wire logic [1:0]  o_watchdog_timeout_select,
    input wire logic        o_short_limit_select,
    input wire logic        o_global_output_enable,
    input wire logic        o_global_regulator_power,
    input wire logic        o_watchdog_fault,
    input wire logic [3:0]  o_channel_power_up,
    input wire logic [3:0]  o_channel_zeroing_select,
    input wire logic [3:0]  o_channel_output_enable,
    input wire logic [3:0]  o_sense_resistor_select,
    input wire logic [3:0]  o_channel_regulator_power,
    input wire logic [3:0]  o_voltage_overrange_enable,
    input wire logic [11:0] o_output_range_select,
    // strobes
    input wire logic        o_slew_wr,
    input wire logic        o_regulator_ctrl_wr,
    input wire logic        o_software_wr,
    input wire logic [15:0] o_ctrl_data
);
    timeunit 1ns;
    timeprecision 1ps;
    wire       ctl = i_word_vld && (i_word[20:18] == 3'h7);
    wire [2:0] sub = i_word[15:13];
    wire       stb = ctl && (sub == 3'h0 || sub == 3'h3 || sub == 3'h4);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    property p_slew; ctl && sub == 3'h0 |=> o_slew_wr; endproperty
    a_slew: assert property (p_slew) else $error("slew strobe missing");
    property p_regw; ctl && sub == 3'h3 |=> o_regulator_ctrl_wr; endproperty
    a_regw: assert property (p_regw) else $error("regulator strobe missing");
    property p_soft; ctl && sub == 3'h4 |=> o_software_wr; endproperty
    a_soft: assert property (p_soft) else $error("software strobe missing");
    property p_none;
        !stb |=> !(o_slew_wr || o_regulator_ctrl_wr || o_software_wr);
    endproperty
    a_none: assert property (p_none) else $error("stray strobe");
    property p_data; ctl |=> o_ctrl_data == $past(i_word[15:0]); endproperty
    a_data: assert property (p_data) else $error("control data wrong");
    property p_main;
        ctl && sub == 3'h1 |=> ##1 {o_status_readback_enable, o_watchdog_enable,
            o_watchdog_timeout_select, o_short_limit_select, o_global_output_enable,
            o_global_regulator_power} == $past({i_word[11:8], i_word[6:4]}, 2);
    endproperty
    a_main: assert property (p_main) else $error("main fields wrong");
    property p_oeall; $past(o_global_output_enable) |-> &o_channel_output_enable; endproperty
    a_oeall: assert property (p_oeall) else $error("global enable not on all");
    property p_regall;
        $past(o_global_regulator_power) |-> &o_channel_regulator_power;
    endproperty
    a_regall: assert property (p_regall) else $error("global regulator not on all");
    property p_chan0;
        ctl && sub == 3'h2 && i_word[17:16] == 2'h0 |=> ##1 {o_channel_power_up[0],
            o_channel_zeroing_select[0], o_sense_resistor_select[0],
            o_voltage_overrange_enable[0], o_output_range_select[2:0]}
            == $past({i_word[8:7], i_word[5], i_word[3:0]}, 2);
    endproperty
    a_chan0: assert property (p_chan0) else $error("channel 0 fields wrong");
    property p_keep3;
        ctl && sub == 3'h2 && i_word[17:16] != 2'h3 |=> ##1 $stable(o_output_range_select[11:9]);
    endproperty
    a_keep3: assert property (p_keep3) else $error("other channel changed");
    property p_wdoff; !o_watchdog_enable [*3] |-> !o_watchdog_fault; endproperty
    a_wdoff: assert property (p_wdoff) else $error("fault while watchdog off");
endmodule // dcr_monitor
bind dcr_top dcr_monitor i_mon (.i_clk_sys, .i_rst_n, .i_word_vld, .i_word,
    .o_status_readback_enable, .o_watchdog_enable, .o_watchdog_timeout_select,
    .o_short_limit_select, .o_global_output_enable, .o_global_regulator_power,
    .o_watchdog_fault, .o_channel_power_up, .o_channel_zeroing_select,
    .o_channel_output_enable, .o_sense_resistor_select, .o_channel_regulator_power,
    .o_voltage_overrange_enable, .o_output_range_select, .o_slew_wr,
    .o_regulator_ctrl_wr, .o_software_wr, .o_ctrl_data);
`default_nettype wire

/* dcr_host.sv */
/* dcr_host.sv: host side, hands framed words to the block one per cycle.
   Assumes the bench fills q; words leave back to back. */
`default_nettype none
module dcr_host
(
    // clock
    input  wire logic        i_clk_sys,
    // word out
    output var  logic        o_word_vld,
    output var  logic [23:0] o_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] q [$];
    initial
    begin
        o_word_vld = 1'b0;
        o_word     = 24'h000000;
    end
    // idle word toggles so a stale value is never taken for data
    always @(posedge i_clk_sys)
    begin
        o_word_vld <= (q.size() != 0);
        o_word     <= (q.size() != 0) ? q.pop_front() : ~o_word;
    end
endmodule // dcr_host
`default_nettype wire

/* dcr_top_tb.sv */
/* dcr_top_tb.sv: self-checking bench for dcr_top with a field model.
   Assumes shortened watchdog counts 20/40/80/160 cycles. */
`default_nettype none
module dcr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, vld, pin, fault_e;
    logic [23:0] word, w;
    logic [15:0] main_e;
    logic [8:0]  chan_e [4];
    logic [47:0] exp_q [$];
    int          due_q [$];
    int          cyc, err_total, comparisons, seed, n, k;
    wire  [47:0] act;
    dcr_host i_host (.i_clk_sys(clk), .o_word_vld(vld), .o_word(word));
    dcr_top #(.WD_CYC0(20), .WD_CYC1(40), .WD_CYC2(80), .WD_CYC3(160)) i_dut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_word_vld(vld), .i_word(word),
        .i_polarity_pin(pin), .o_status_readback_enable(act[0]),
        .o_watchdog_enable(act[1]), .o_watchdog_timeout_select(act[3:2]),
        .o_short_limit_select(act[4]), .o_global_output_enable(act[5]),
        .o_global_regulator_power(act[6]), .o_watchdog_fault(act[47]),
        .o_channel_power_up(act[10:7]), .o_channel_zeroing_select(act[14:11]),
        .o_channel_output_enable(act[18:15]), .o_sense_resistor_select(act[22:19]),
        .o_channel_regulator_power(act[26:23]), .o_voltage_overrange_enable(act[30:27]),
        .o_output_range_select(act[42:31]), .o_voltage_pin_level(act[46:43]),
        .o_slew_wr(), .o_regulator_ctrl_wr(), .o_software_wr(), .o_ctrl_data());
    function automatic logic [23:0] cw(input logic [1:0] ch, input logic [2:0] sb,
                                       input logic [12:0] d);
        return {3'h0, 3'h7, ch, sb, d};
    endfunction
    function automatic logic [47:0] snap();
        logic [47:0] s;
        s = {fault_e, 40'h0, main_e[4], main_e[5], main_e[6], main_e[9:8], main_e[10],
             main_e[11]};
        for (int c = 0; c < 4; c++)
        begin
            s[43+c]     = pin ^ main_e[12];
            s[31+3*c+:3] = chan_e[c][2:0];
            s[27+c]     = chan_e[c][3];
            s[23+c]     = chan_e[c][4] | main_e[4];
            s[19+c]     = chan_e[c][5];
            s[15+c]     = chan_e[c][6] | main_e[5];
            s[11+c]     = chan_e[c][7];
            s[7+c]      = chan_e[c][8];
        end
        return s;
    endfunction
    task automatic put(input logic [23:0] x);
        i_host.q.push_back(x);
        if (x[20:18] == 3'h7 && x[15:13] == 3'h1) main_e = x[15:0];
        if (x[20:18] == 3'h7 && x[15:13] == 3'h2) chan_e[x[17:16]] = x[8:0];
    endtask
    task automatic note(input int d);
        exp_q.push_back(snap());
        due_q.push_back(cyc + d);
    endtask
    task automatic settle();
        @(posedge clk);
        while (i_host.q.size() != 0) @(posedge clk);
        note(6);
        repeat (7) @(posedge clk);
    endtask
    task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            err_total++;
            stop_test();
        end
    end
    // oldest note is compared once its cycle is reached
    always @(negedge clk)
        if (due_q.size() != 0 && cyc >= due_q[0])
        begin
            void'(due_q.pop_front());
            check("fields", act, exp_q.pop_front());
        end
    initial
    begin
        {cyc, err_total, comparisons, seed} = {96'h0, 32'h2cda};
        {rst_n, pin, fault_e, main_e} = 19'h0;
        chan_e = '{default: 9'h000};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        for (n = 0; n < 8; n++) put(cw(2'h1, n[2:0], 13'h1E8B));
        put({3'h0, 3'h3, 2'h0, 3'h1, 13'h0000});
        settle();
        put(cw(2'h0, 3'h1, 13'h0000));
        put(cw(2'h1, 3'h2, 13'h0000));
        settle();
        $display("test decode done");
        repeat (30)
        begin
            k = 1 + {$random(seed)} % 3;
            repeat (k)
            begin
                w = 24'($random(seed));
                if (w[23]) w[20:18] = 3'h7;
                w[23] = 1'b0;
                if (w[15:13] == 3'h1) {w[10], w[5:4]} = 3'h0;
                if (w[15:13] == 3'h2 && !w[4]) w[8:6] = w[8:6] & 3'h2;
                if (w[2:0] == 3'h7) w[2:0] = 3'h3;
                put(w);
            end
            settle();
        end
        $display("test random done");
        for (n = 0; n < 4; n++) put(cw(n[1:0], 3'h2, 13'h0000));
        for (n = 0; n < 3; n++) put(cw(2'h0, 3'h1, {8'h00, w[n], 4'h0}));
        put(cw(2'h0, 3'h1, 13'h0010));
        settle();
        put(cw(2'h0, 3'h1, 13'h0030));
        settle();
        put(cw(2'h0, 3'h1, 13'h0010));
        settle();
        put(cw(2'h0, 3'h1, 13'h0000));
        put(cw(2'h2, 3'h2, 13'h0110));
        settle();
        repeat (20000) @(posedge clk);
        put(cw(2'h2, 3'h2, 13'h0150));
        settle();
        put(cw(2'h2, 3'h2, 13'h0000));
        settle();
        $display("test enables done");
        pin <= 1'b1;
        settle();
        put(cw(2'h0, 3'h1, 13'h1000));
        settle();
        pin <= 1'b0;
        settle();
        $display("test polarity done");
        for (n = 0; n < 4; n++)
        begin
            put(cw(2'h0, 3'h1, 13'h0400 | 13'(n << 8)));
            settle();
            note((20 << n) - 12);
            fault_e = 1'b1;
            note(20 << n);
            repeat ((20 << n) + 2) @(posedge clk);
            put(cw(2'h0, 3'h4, 13'h0195));
            fault_e = 1'b0;
            settle();
            put(cw(2'h0, 3'h1, 13'h0000));
            settle();
        end
        $display("test watchdog done");
        stop_test();
    end
endmodule // dcr_top_tb
`default_nettype wire
